// ===== rtw_link.sv
// Transponder link top: standby windows, receive entry, write-word command
`timescale 1ns/1ns

// Behaviour
// R1: Address is 4 bits plus even parity
// R2: Four data blocks, 4 bits plus even parity
// R3: Final block: column parities then a zero
// R4: All checks pass: acknowledge, then program EEPROM
// R5: Programming done: send a second acknowledge
// R6: Failed parity or guard: no-acknowledge, standby
// R7: Corrupt frame may return silently to standby
// R8: Hold reset until supply good, with hysteresis
// R9: Sequencing timed by recovered carrier clock
// R10: Reader tolerates one clock drift per bit
// R11: Outgoing data bits are Manchester encoded
// R12: Status patterns unlike any Manchester bit stream
// R13: Receive entry accepted only during listen window
// R14: Reader sends zero in window's modulated phase
// R15: First zero stops window; second zero enters receive
// R16: Each received bit spans 32 carrier periods
// R17: Modulator on first 16 clocks of bit
// R18: Reader sends one by leaving field on
// R19: Reader sends zero by cutting field early
// R20: Reader cuts field between clocks 1 and 16
// R21: Reader inserts zeros regularly for resync
// R22: Standby repeats 160-period listen windows
// R23: Write allowed only with guard bits one, zero
// R24: Command is 3 bits plus even parity
// R25: Column parity is even across data blocks
module rtw_link (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Recovered carrier and demodulated field envelope
   input wire logic carrier_clk_i,
   input wire logic field_on_i,
   // Supply monitor comparators
   input wire logic supply_on_i,
   input wire logic supply_hold_i,
   // Write-guard bits from memory
   input wire logic write_guard_upper_i,
   input wire logic write_guard_lower_i,
   // Load modulator
   output logic mod_o,
   // EEPROM programming port
   output logic ee_we_o,
   output logic [rtw_pkg::RTW_ADDR_W-1:0] ee_addr_o,
   output logic [rtw_pkg::RTW_DATA_W-1:0] ee_data_o
);
   import rtw_pkg::*;

   typedef enum logic [3:0] {
      RTW_ST_LIW, RTW_ST_SYNC, RTW_ST_CMD, RTW_ST_DATA, RTW_ST_CHECK,
      RTW_ST_ACK1, RTW_ST_PROG, RTW_ST_ACK2, RTW_ST_NAK
   } rtw_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Even parity holds when the block has an even count of ones
   function automatic logic rtw_even_ok(input logic [4:0] blk);
      rtw_even_ok = ~^blk;
   endfunction : rtw_even_ok

   // Status pattern to play in a given state
   function automatic logic [9:0] rtw_pattern(input rtw_state_t st);
      unique case (st)
         RTW_ST_ACK1, RTW_ST_ACK2: rtw_pattern = RTW_PAT_ACK;
         RTW_ST_NAK: rtw_pattern = RTW_PAT_NAK;
         default: rtw_pattern = RTW_PAT_LISTEN;
      endcase
   endfunction : rtw_pattern

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic [2:0] clk_sync_reg;
   logic [2:0] field_sync_reg;
   logic [1:0] son_sync_reg;
   logic [1:0] shold_sync_reg;
   logic tick;
   logic field_fall;

   // Two flops per carrier, field and supply input, third stage for edge finding
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         clk_sync_reg <= 3'h0;
         field_sync_reg <= 3'h7;
         son_sync_reg <= 2'h0;
         shold_sync_reg <= 2'h0;
      end
      else
      begin
         clk_sync_reg <= {clk_sync_reg[1:0], carrier_clk_i};
         field_sync_reg <= {field_sync_reg[1:0], field_on_i};
         son_sync_reg <= {son_sync_reg[0], supply_on_i};
         shold_sync_reg <= {shold_sync_reg[0], supply_hold_i};
      end
   end

   // One enable per carrier period
   assign tick = clk_sync_reg[1] && !clk_sync_reg[2]; // [R9]
   assign field_fall = !field_sync_reg[1] && field_sync_reg[2];

   ////////////////////////////////////////////////////////////////////////////
   // Power-on hold with hysteresis

   logic run_reg;
   logic lrst;

   // Start above the upper level, stop only below the lower one
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         run_reg <= 1'b0;
      end
      else if (son_sync_reg[1])
      begin
         run_reg <= 1'b1; // [R8]
      end
      else if (!shold_sync_reg[1])
      begin
         run_reg <= 1'b0; // [R8]
      end
   end

   assign lrst = rst_i || !run_reg; // [R8]

   ////////////////////////////////////////////////////////////////////////////
   // Transmit path: pattern pusher, FIFO, modulator driver

   rtw_stream_if #(.WIDTH(RTW_SYM_W)) push_s ();
   rtw_stream_if #(.WIDTH(RTW_SYM_W)) pop_s ();

   rtw_state_t state_reg;
   logic [3:0] push_cnt_reg;
   logic flush_reg;
   logic tx_mod;
   logic tx_idle;
   logic pushing;
   logic drained;
   logic [9:0] pat;

   assign pat = rtw_pattern(state_reg);
   assign pushing = (state_reg == RTW_ST_LIW) || (state_reg == RTW_ST_ACK1) ||
                    (state_reg == RTW_ST_ACK2) || (state_reg == RTW_ST_NAK);
   assign push_s.valid = pushing && (push_cnt_reg < 4'(RTW_PATT_CHIPS)) && !flush_reg;
   // Raw chips only, with runs that Manchester data never shows
   assign push_s.data = {1'b0, pat[4'(RTW_PATT_CHIPS - 1) - push_cnt_reg]}; // [R12]
   assign drained = (push_cnt_reg == 4'(RTW_PATT_CHIPS)) && !pop_s.valid && tx_idle;

   rtw_fifo #(.WIDTH(RTW_SYM_W), .DEPTH(RTW_FIFO_DEPTH)) u_fifo (
      .sys_clk_i(sys_clk_i),
      .rst_i(lrst),
      .flush_i(flush_reg),
      .in_s(push_s),
      .out_s(pop_s)
   );

   rtw_modtx u_tx (
      .sys_clk_i(sys_clk_i),
      .rst_i(lrst),
      .flush_i(flush_reg),
      .tick_i(tick),
      .sym_s(pop_s),
      .mod_o(tx_mod),
      .idle_o(tx_idle)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Receive bit timing

   logic [4:0] bit_cnt_reg;
   logic zero_seen_reg;
   logic bit_end;
   logic bit_val;
   logic rx_active;
   logic liw_entry;

   assign rx_active = (state_reg == RTW_ST_SYNC) || (state_reg == RTW_ST_CMD) ||
                      (state_reg == RTW_ST_DATA);
   // Zero only counts while the window's modulated phase plays
   assign liw_entry = (state_reg == RTW_ST_LIW) && tx_mod && field_fall; // [R13] [R14]
   assign bit_end = rx_active && tick && !field_fall &&
                    (bit_cnt_reg == 5'(RTW_BIT_PERIODS - 1)); // [R16]
   assign bit_val = !zero_seen_reg;

   // Field cut realigns the frame and marks the bit as zero
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
      begin
         bit_cnt_reg <= 5'h00;
         zero_seen_reg <= 1'b0;
      end
      else if (liw_entry || (rx_active && field_fall))
      begin
         bit_cnt_reg <= RTW_RESYNC_CNT; // [R21] [R10]
         zero_seen_reg <= 1'b1;
      end
      else if (bit_end)
      begin
         bit_cnt_reg <= 5'h00;
         zero_seen_reg <= 1'b0;
      end
      else if (rx_active && tick)
      begin
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command and frame assembly

   logic [RTW_CMD_BITS-1:0] cmd_reg;
   logic [RTW_WR_BITS-1:0] wr_reg;
   logic [4:0] nbits_reg;
   logic [3:0] blk_d [4];
   logic [4:0] blk_a;
   logic [4:0] blk_c;
   logic row_ok;
   logic col_ok;
   logic guard_ok;
   logic cmd_ok;

   // First received bit ends up in the MSB
   always_comb
   begin
      blk_a = wr_reg[29:25];
      blk_c = wr_reg[4:0];
      for (int i = 0; i < 4; i++)
      begin
         blk_d[i] = wr_reg[24 - 5 * i -: 4];
      end
   end

   assign row_ok = rtw_even_ok(blk_a) && rtw_even_ok(wr_reg[24:20]) && // [R1] [R2]
                   rtw_even_ok(wr_reg[19:15]) && rtw_even_ok(wr_reg[14:10]) &&
                   rtw_even_ok(wr_reg[9:5]);
   assign col_ok = ((blk_d[0] ^ blk_d[1] ^ blk_d[2] ^ blk_d[3]) == blk_c[4:1]); // [R3] [R25]
   assign guard_ok = write_guard_upper_i && !write_guard_lower_i; // [R23]
   assign cmd_ok = (^{cmd_reg[2:0], bit_val} == 1'b0) && (cmd_reg[2:0] == RTW_CMD_WRITE); // [R24]

   // Shift in command and frame bits
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
      begin
         cmd_reg <= '0;
         wr_reg <= '0;
      end
      else if (bit_end && (state_reg == RTW_ST_CMD))
      begin
         cmd_reg <= {cmd_reg[2:0], bit_val};
      end
      else if (bit_end && (state_reg == RTW_ST_DATA))
      begin
         wr_reg <= {wr_reg[RTW_WR_BITS-2:0], bit_val};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequencer

   logic [11:0] prog_cnt_reg;
   logic prog_done;

   assign prog_done = tick && (prog_cnt_reg == 12'(RTW_PROG_PERIODS - 1));

   // Link state flow
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
      begin
         state_reg <= RTW_ST_LIW;
         nbits_reg <= 5'h00;
      end
      else
      begin
         unique case (state_reg)
            RTW_ST_LIW:
               if (liw_entry)
               begin
                  nbits_reg <= 5'h00;
                  state_reg <= RTW_ST_SYNC; // [R15]
               end
            RTW_ST_SYNC:
               // First frame is the entry zero itself; judge the one after it
               if (bit_end && (nbits_reg == 5'h00))
               begin
                  nbits_reg <= 5'h01; // [R15]
               end
               else if (bit_end)
               begin
                  nbits_reg <= 5'h00;
                  state_reg <= bit_val ? RTW_ST_LIW : RTW_ST_CMD; // [R15]
               end
            RTW_ST_CMD:
               if (bit_end)
               begin
                  nbits_reg <= nbits_reg + 5'h01;
                  if (nbits_reg == 5'(RTW_CMD_BITS - 1))
                  begin
                     nbits_reg <= 5'h00;
                     state_reg <= cmd_ok ? RTW_ST_DATA : RTW_ST_LIW; // [R24]
                  end
               end
            RTW_ST_DATA:
               if (bit_end)
               begin
                  nbits_reg <= nbits_reg + 5'h01;
                  if (nbits_reg == 5'(RTW_WR_BITS - 1))
                  begin
                     state_reg <= RTW_ST_CHECK;
                  end
               end
            RTW_ST_CHECK:
               if (blk_c[0])
               begin
                  state_reg <= RTW_ST_LIW; // [R7]
               end
               else if (row_ok && col_ok && guard_ok)
               begin
                  state_reg <= RTW_ST_ACK1; // [R4]
               end
               else
               begin
                  state_reg <= RTW_ST_NAK; // [R6]
               end
            RTW_ST_ACK1:
               if (drained)
               begin
                  state_reg <= RTW_ST_PROG; // [R4]
               end
            RTW_ST_PROG:
               if (prog_done)
               begin
                  state_reg <= RTW_ST_ACK2; // [R5]
               end
            RTW_ST_ACK2, RTW_ST_NAK:
               if (drained)
               begin
                  state_reg <= RTW_ST_LIW; // [R6]
               end
         endcase
      end
   end

   // Chip pusher: windows loop, other patterns play once
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst || (pushing && drained) || liw_entry)
      begin
         push_cnt_reg <= 4'h0;
      end
      else if (push_s.valid && push_s.ready)
      begin
         if ((state_reg == RTW_ST_LIW) && (push_cnt_reg == 4'(RTW_PATT_CHIPS - 1)))
         begin
            push_cnt_reg <= 4'h0; // [R22]
         end
         else
         begin
            push_cnt_reg <= push_cnt_reg + 4'h1;
         end
      end
   end

   // Abort the window at once on the first zero
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
      begin
         flush_reg <= 1'b0;
      end
      else
      begin
         flush_reg <= liw_entry; // [R15]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // EEPROM programming and output registers

   // Programming time counted in carrier periods
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst || (state_reg != RTW_ST_PROG))
      begin
         prog_cnt_reg <= 12'h000;
      end
      else if (tick)
      begin
         prog_cnt_reg <= prog_cnt_reg + 12'h001;
      end
   end

   // Write strobe held for the whole programming time
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
      begin
         ee_we_o <= 1'b0;
         ee_addr_o <= '0;
         ee_data_o <= '0;
      end
      else
      begin
         ee_we_o <= (state_reg == RTW_ST_PROG) && !prog_done; // [R4] [R5]
         if (state_reg == RTW_ST_ACK1)
         begin
            ee_addr_o <= blk_a[4:1];
            ee_data_o <= {blk_d[0], blk_d[1], blk_d[2], blk_d[3]};
         end
      end
   end

   // Modulator: bit-frame loading while receiving, patterns otherwise
   always_ff @(posedge sys_clk_i)
   begin
      if (lrst)
      begin
         mod_o <= 1'b0;
      end
      else if (rx_active)
      begin
         mod_o <= (bit_cnt_reg < 5'(RTW_HALF_PERIODS)); // [R17]
      end
      else
      begin
         mod_o <= tx_mod;
      end
   end

endmodule : rtw_link

// ===== rtw_pkg.sv
// Shared constants for the contactless tag link write-word block
package rtw_pkg;

   // Carrier-period timing of the link
   localparam int RTW_BIT_PERIODS = 32;
   localparam int RTW_HALF_PERIODS = 16;
   localparam int RTW_PATT_PERIODS = 160;
   localparam int RTW_PROG_PERIODS = 3072;
   localparam int RTW_PATT_CHIPS = RTW_PATT_PERIODS / RTW_HALF_PERIODS;

   // Field cut seen: bit counter realigns to this carrier index
   localparam logic [4:0] RTW_RESYNC_CNT = 5'h04;

   // Frame layout of a write-word command
   localparam int RTW_CMD_BITS = 4;
   localparam int RTW_BLOCK_BITS = 5;
   localparam int RTW_WR_BITS = 30;
   localparam int RTW_ADDR_W = 4;
   localparam int RTW_DATA_W = 16;

   // Write-word command code (three code bits)
   localparam logic [2:0] RTW_CMD_WRITE = 3'h5;

   // Status patterns as ten 16-period chips, first chip in the MSB
   localparam logic [9:0] RTW_PAT_LISTEN = 10'h060;
   localparam logic [9:0] RTW_PAT_ACK = 10'h38a;
   localparam logic [9:0] RTW_PAT_NAK = 10'h3b8;

   // Transmit symbol: bit 1 set means Manchester data bit, else raw chip
   localparam int RTW_SYM_W = 2;
   localparam int RTW_FIFO_DEPTH = 8;

endpackage : rtw_pkg

// ===== rtw_stream_if.sv
// Valid/ready stream carrying transmit symbols between the block's modules
`timescale 1ns/1ns
interface rtw_stream_if #(parameter int WIDTH = 2);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : rtw_stream_if

// ===== rtw_fifo.sv
// Symbol FIFO between the pattern sequencer and the modulator driver
`timescale 1ns/1ns
module rtw_fifo #(
   parameter int WIDTH = rtw_pkg::RTW_SYM_W,
   parameter int DEPTH = rtw_pkg::RTW_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic flush_i,
   // Streams
   rtw_stream_if.snk in_s,
   rtw_stream_if.src out_s
);
   import rtw_pkg::*;

   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_chk
      $error("rtw_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic full;
   logic empty;

   // Honest flags from pointer comparison
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign in_s.ready = !full;
   assign out_s.valid = !empty;
   assign out_s.data = mem_reg[rd_ptr_reg[AW-1:0]];

   // Storage write
   always_ff @(posedge sys_clk_i)
   begin
      if (in_s.valid && !full)
      begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_s.data;
      end
   end

   // Pointers, cleared by reset or flush
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || flush_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end
      else
      begin
         if (in_s.valid && !full)
         begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (out_s.ready && !empty)
         begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

endmodule : rtw_fifo

// ===== rtw_modtx.sv
// Modulator driver: plays raw chips and Manchester data bits per carrier tick
`timescale 1ns/1ns
module rtw_modtx (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic flush_i,
   // Carrier period enable
   input wire logic tick_i,
   // Symbol stream
   rtw_stream_if.snk sym_s,
   // Modulator state
   output logic mod_o,
   output logic idle_o
);
   import rtw_pkg::*;

   logic busy_reg;
   logic mod_reg;
   logic second_reg;
   logic [3:0] cnt_reg;
   logic chip_end;

   // Chip ends after sixteen carrier periods
   assign chip_end = busy_reg && tick_i && (cnt_reg == 4'(RTW_HALF_PERIODS - 1));
   assign sym_s.ready = !second_reg && (!busy_reg || chip_end);
   assign mod_o = mod_reg;
   assign idle_o = !busy_reg;

   // Chip sequencing; a data bit becomes chip then its inverse
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || flush_i)
      begin
         busy_reg <= 1'b0;
         mod_reg <= 1'b0;
         second_reg <= 1'b0;
         cnt_reg <= 4'h0;
      end
      else if (sym_s.valid && sym_s.ready)
      begin
         busy_reg <= 1'b1;
         cnt_reg <= 4'h0;
         mod_reg <= sym_s.data[0];
         second_reg <= sym_s.data[1]; // [R11]
      end
      else if (chip_end)
      begin
         cnt_reg <= 4'h0;
         if (second_reg)
         begin
            mod_reg <= ~mod_reg; // [R11]
            second_reg <= 1'b0;
         end
         else
         begin
            busy_reg <= 1'b0;
            mod_reg <= 1'b0;
         end
      end
      else if (busy_reg && tick_i)
      begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end

endmodule : rtw_modtx

// ===== rtw_link_sva.sv
// Concurrent checks on the tag link top ports
`timescale 1ns/1ns
module rtw_link_sva (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Link, supply and guard inputs
   input wire logic carrier_clk_i,
   input wire logic field_on_i,
   input wire logic supply_on_i,
   input wire logic supply_hold_i,
   input wire logic write_guard_upper_i,
   input wire logic write_guard_lower_i,
   // Outputs watched
   input wire logic mod_o,
   input wire logic ee_we_o,
   input wire logic [rtw_pkg::RTW_ADDR_W-1:0] ee_addr_o,
   input wire logic [rtw_pkg::RTW_DATA_W-1:0] ee_data_o
);
   import rtw_pkg::*;
   logic [2:0] car_reg;
   logic [13:0] hi_reg;
   logic [13:0] lo_reg;
   logic [13:0] we_reg;
   logic tick;
   assign tick = car_reg[1] & ~car_reg[2];
   ////////////////////////////////////////////////////////////////////////////////
   // Carrier edge finder
   always_ff @(posedge sys_clk_i)
   begin
      car_reg <= {car_reg[1:0], carrier_clk_i};
   end
   // Ticks of modulator on, modulator off and strobe high
   always_ff @(posedge sys_clk_i)
   begin
      hi_reg <= (rst_i || !mod_o) ? 14'h0 : hi_reg + {13'h0, tick};
      lo_reg <= (rst_i || mod_o || ee_we_o || !supply_on_i) ? 14'h0 : lo_reg + {13'h0, tick};
      we_reg <= (rst_i || !ee_we_o) ? 14'h0 : we_reg + {13'h0, tick};
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence we_start_s;
      $rose(ee_we_o);
   endsequence
   sequence we_end_s;
      $fell(ee_we_o);
   endsequence
   reset_quiet_a: assert property ($fell(rst_i) |-> !mod_o && !ee_we_o)
      else $error("outputs active after reset");
   supply_low_a: assert property (!supply_hold_i [*6] |-> !mod_o && !ee_we_o)
      else $error("activity with low supply");
   guard_ok_a: assert property (we_start_s |-> write_guard_upper_i && !write_guard_lower_i)
      else $error("write with closed guard");
   we_hold_a: assert property (ee_we_o && $past(ee_we_o) |-> $stable({ee_addr_o, ee_data_o}))
      else $error("address or data moved during write");
   we_length_a: assert property (we_end_s |-> we_reg >= 14'd3070 && we_reg <= 14'd3074)
      else $error("programming length wrong");
   ack_before_a: assert property (we_start_s |-> lo_reg >= 14'd14 && lo_reg <= 14'd18)
      else $error("write not preceded by acknowledge");
   ack_after_a: assert property (we_end_s |-> ##[1:40] mod_o)
      else $error("no acknowledge after programming");
   mod_high_run_a: assert property (hi_reg <= 14'd50)
      else $error("modulator on too long");
   mod_low_run_a: assert property (lo_reg <= 14'd130)
      else $error("listen windows missing");
endmodule : rtw_link_sva

bind rtw_link rtw_link_sva u_rtw_link_sva (.sys_clk_i, .rst_i, .carrier_clk_i, .field_on_i,
   .supply_on_i, .supply_hold_i, .write_guard_upper_i, .write_guard_lower_i, .mod_o, .ee_we_o,
   .ee_addr_o, .ee_data_o);

// ===== rtw_reader.sv
// Reader transceiver model: carrier source, field gate and bit sender
`timescale 1ns/1ns
module rtw_reader (
   // Tag modulator as seen on the field
   input wire logic mod_i,
   // Carrier and field envelope
   output logic carrier_clk_o,
   output logic field_on_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Field up at start
   initial
   begin
      carrier_clk_o = 1'b0;
      field_on_o = 1'b1;
   end
   // Carrier of 80 ns, phase unrelated to the system clock
   always #40 carrier_clk_o = ~carrier_clk_o;
   ////////////////////////////////////////////////////////////////////////////////
   // Wait a number of carrier periods
   task automatic ticks(input int n);
      repeat (n) @(posedge carrier_clk_o);
   endtask : ticks
   // One bit of 32 periods; a zero cuts the field over clocks 5 to 16
   task automatic send_bit(input logic b);
      if (b)
         ticks(32);
      else
      begin
         ticks(4);
         field_on_o <= 1'b0;
         ticks(12);
         field_on_o <= 1'b1;
         ticks(16);
      end
   endtask : send_bit
   // Two zeros, the first inside the window's modulated phase
   task automatic enter_rx();
      @(posedge mod_i);
      @(posedge carrier_clk_o);
      send_bit(1'b0);
      send_bit(1'b0);
   endtask : enter_rx
endmodule : rtw_reader

// ===== rtw_link_bench.sv
// Self-checking bench for the tag link write-word block
`timescale 1ns/1ns
module rtw_link_bench;
   import rtw_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic supply_on_i = 1'b0;
   logic supply_hold_i = 1'b0;
   logic write_guard_upper_i = 1'b1;
   logic write_guard_lower_i = 1'b0;
   logic carrier_clk_i, field_on_i, mod_o, ee_we_o;
   logic [RTW_ADDR_W-1:0] ee_addr_o;
   logic [RTW_DATA_W-1:0] ee_data_o;
   logic we_seen = 1'b0;
   int errors = 0;
   int tests_run = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Design, far side and clock
   rtw_link u_rtw_link (.sys_clk_i, .rst_i, .carrier_clk_i, .field_on_i, .supply_on_i,
      .supply_hold_i, .write_guard_upper_i, .write_guard_lower_i, .mod_o, .ee_we_o,
      .ee_addr_o, .ee_data_o);
   rtw_reader u_rtw_reader (.mod_i(mod_o), .carrier_clk_o(carrier_clk_i),
      .field_on_o(field_on_i));
   always #5 sys_clk_i = ~sys_clk_i;
   // Sticky record of any programming strobe
   always @(posedge sys_clk_i)
      if (ee_we_o === 1'b1) we_seen <= 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Counts and verdict
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test
   // Frame: address, four data rows, column parities, trailing zero
   function automatic logic [29:0] frame(input logic [3:0] a, input logic [15:0] d);
      logic [3:0] col;
      col = d[15:12] ^ d[11:8] ^ d[7:4] ^ d[3:0];
      return {a, ^a, d[15:12], ^d[15:12], d[11:8], ^d[11:8], d[7:4], ^d[7:4],
         d[3:0], ^d[3:0], col, 1'b0};
   endfunction : frame
   // Ten chips sampled mid-chip, first chip in the MSB
   task automatic get_pattern(output logic [9:0] p);
      for (int i = 9; i >= 0; i--)
      begin
         u_rtw_reader.ticks(8);
         p[i] = mod_o;
         u_rtw_reader.ticks(8);
      end
   endtask : get_pattern
   // Entry, command, optional frame with one bit flipped, then the answer
   task automatic write_word(input string name, input logic [2:0] code, input logic [3:0] a,
         input logic [15:0] d, input int flip, input logic [9:0] exp);
      logic [29:0] f;
      logic [9:0] p;
      logic [3:0] c;
      f = frame(a, d);
      if (flip >= 0) f[flip] = ~f[flip];
      c = {code, ^code};
      we_seen <= 1'b0;
      u_rtw_reader.enter_rx();
      for (int i = 3; i >= 0; i--) u_rtw_reader.send_bit(c[i]);
      if (code === RTW_CMD_WRITE)
         for (int i = 29; i >= 0; i--) u_rtw_reader.send_bit(f[i]);
      get_pattern(p);
      check({6'h0, p}, {6'h0, exp});
      if (exp === RTW_PAT_ACK)
      begin
         for (int k = 0; k < 40 && ee_we_o !== 1'b1; k++) @(posedge sys_clk_i);
         check({12'h0, ee_addr_o}, {12'h0, a});
         check(ee_data_o, d);
         for (int k = 0; k < 30000 && ee_we_o !== 1'b0; k++) @(posedge sys_clk_i);
         get_pattern(p);
         check({6'h0, p}, {6'h0, RTW_PAT_ACK});
      end
      else
      begin
         check({15'h0, we_seen}, 16'h0);
         if (exp === RTW_PAT_NAK) get_pattern(p);
         if (exp === RTW_PAT_NAK) check({6'h0, p}, {6'h0, RTW_PAT_LISTEN});
      end
      $display("Test %s done", name);
   endtask : write_word
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog sized a little above the expected run
   initial
   begin
      #1100000;
      errors++;
      finish_test();
   end
   // Main sequence
   initial
   begin
      logic [2:0] c;
      logic [9:0] p;
      void'($urandom(32'hdf635203));
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (20) @(posedge sys_clk_i);
      check({15'h0, mod_o}, 16'h0);
      supply_hold_i <= 1'b1;
      supply_on_i <= 1'b1;
      write_word("good", RTW_CMD_WRITE, 4'($urandom), 16'($urandom), -1, RTW_PAT_ACK);
      write_word("row", RTW_CMD_WRITE, 4'($urandom), 16'($urandom), 20, RTW_PAT_NAK);
      write_word("col", RTW_CMD_WRITE, 4'($urandom), 16'($urandom), 2, RTW_PAT_NAK);
      @(posedge sys_clk_i);
      write_guard_upper_i <= 1'b0;
      write_word("guard", RTW_CMD_WRITE, 4'($urandom), 16'($urandom), -1, RTW_PAT_NAK);
      @(posedge sys_clk_i);
      write_guard_upper_i <= 1'b1;
      write_word("tail", RTW_CMD_WRITE, 4'($urandom), 16'($urandom), 0, RTW_PAT_LISTEN);
      // Stray zero in the window's off phase; windows go on, two chips later
      u_rtw_reader.send_bit(1'b0);
      get_pattern(p);
      check({6'h0, p}, {6'h0, RTW_PAT_LISTEN[7:0], RTW_PAT_LISTEN[9:8]});
      $display("Test stray done");
      c = 3'($urandom % 7);
      if (c >= 3'h5) c++;
      write_word("code", c, 4'h0, 16'h0, -1, RTW_PAT_LISTEN);
      finish_test();
   end
endmodule : rtw_link_bench
